// ===== hw/msc_consts.svh
// Constants for the serial scan control block: register offsets, fields, resets.
// Assumes inclusion by bare name from the package and the top module.
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define MSC_CTRL_OFS        8'h00
`define MSC_STATUS_OFS      8'h04
`define MSC_GAIN_OFS        8'h08
`define MSC_LASTCMD_OFS     8'h0C

// Control register fields and reset
`define MSC_CTRL_LINK_EN    0
`define MSC_CTRL_RESTART    1
`define MSC_CTRL_RST        1'b1

// Serial command word fields
`define MSC_WORD_BITS       16
`define MSC_OP_MSB          15
`define MSC_OP_LSB          12
`define MSC_CH_MSB          11
`define MSC_CH_LSB          8
`define MSC_ARG_MSB         4
`define MSC_ARG_LSB         0

// Route code of the cold-junction sensor; codes below it are input channels
`define MSC_CJ_CODE         5'h10

// Default module address on the serial link; value is arbitrary
`define MSC_ADDR_RST        8'h01

`endif

// ===== hw/msc_pkg.sv
// Types shared by the serial scan control block.
// Assumes the constants header is on the include path.
package msc_pkg;
`include "msc_consts.svh"

    // Opcodes carried in the top nibble of a serial data word
    typedef enum logic [3:0] {
        MSC_OP_NOP      = 4'b0000,
        MSC_OP_GAIN     = 4'b0001,
        MSC_OP_COUPLE   = 4'b0010,
        MSC_OP_AUTOZERO = 4'b0011,
        MSC_OP_CLEAR    = 4'b0100,
        MSC_OP_PUSH     = 4'b0101
    } msc_op_e;

    typedef logic [`MSC_WORD_BITS-1:0] msc_word_t;
endpackage

// ===== hw/msc_scan_control.sv
// Serial scan control: serial command link, scan list, mux routing, AXI4-Lite registers.
// Assumes the serial clock runs during reset and that the host launches serial
// bits on the falling edge of that clock.
`timescale 1ns/1ps
`include "msc_consts.svh"

// Contract
// - Host sends commands on the inbound serial line
// - Module returns read-back on outbound serial line
// - Both data lines move with host serial clock
// - Qualifier marks address versus data bits
// - Slot-zero traffic is ignored by the module
// - Sixteen channels plus cold junction reach output
// - Each channel holds its own gain 1 or 100
// - Coupling switch picks front terminals or ground
// - Auto-zero overrides the programmed coupling choice
// - Auto-zero grounds inputs for offset measurement
// - Scan list memory holds entries stepped by strobe
// - Entries in any order, repeats allowed
module msc_scan_control
    import msc_pkg::*;
#(
    parameter int          DEPTH     = 16,             // Scan list entries
    parameter logic [7:0]  MOD_ADDR  = `MSC_ADDR_RST   // Link address; value is arbitrary
)
(
    input  wire logic        aclk,                           // System clock
    input  wire logic        aresetn,                        // Synchronous reset, low
    input  wire logic [7:0]  s_axi_awaddr,                   // Write address
    input  wire logic        s_axi_awvalid,                  // Write address valid
    output logic             s_axi_awready,                  // Write address ready
    input  wire logic [31:0] s_axi_wdata,                    // Write data
    input  wire logic [3:0]  s_axi_wstrb,                    // Write byte enables
    input  wire logic        s_axi_wvalid,                   // Write data valid
    output logic             s_axi_wready,                   // Write data ready
    output logic [1:0]       s_axi_bresp,                    // Write response
    output logic             s_axi_bvalid,                   // Write response valid
    input  wire logic        s_axi_bready,                   // Write response ready
    input  wire logic [7:0]  s_axi_araddr,                   // Read address
    input  wire logic        s_axi_arvalid,                  // Read address valid
    output logic             s_axi_arready,                  // Read address ready
    output logic [31:0]      s_axi_rdata,                    // Read data
    output logic [1:0]       s_axi_rresp,                    // Read response
    output logic             s_axi_rvalid,                   // Read data valid
    input  wire logic        s_axi_rready,                   // Read data ready
    input  wire logic        serial_shift_clock,             // Link clock from host
    input  wire logic        host_to_module_serial_line,     // Inbound serial data
    output logic             module_to_host_serial_line,     // Outbound serial data
    output logic             module_to_host_serial_oe_n,     // Low while driving outbound
    input  wire logic        data_not_address_qualifier,     // High address, low data
    input  wire logic        backplane_slot_select_n,        // Low means slot-zero traffic
    input  wire logic        scan_advance_strobe,            // Sample-taken strobe, async
    output logic [4:0]       mux_route_select,               // Routed channel, 16 is CJ
    output logic             mux_gain_100,                   // High selects gain 100
    output logic             mux_input_grounded              // High grounds the inputs
);

    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    // Link-side state, clocked by the serial clock
    typedef struct packed {
        logic            rst_m;
        logic            rst_s;
        logic            en_m;
        logic            en_s;
        logic [7:0]      addr_sh;
        logic [3:0]      bit_cnt;
        msc_word_t       in_sh;
        msc_word_t       out_sh;
        msc_word_t       word_hold;
        logic            word_tgl;
    } msc_link_s;

    // System-side state, clocked by aclk
    typedef struct packed {
        logic                  tgl_m;
        logic                  tgl_s;
        logic                  tgl_d;
        logic                  stb_m;
        logic                  stb_s;
        logic                  stb_d;
        logic                  link_en;
        logic [15:0]           gain;
        logic                  ground_sel;
        logic                  az_en;
        logic                  az_pend;
        logic [DEPTH-1:0][4:0] list;
        logic [CW-1:0]         count;
        logic [PW-1:0]         ptr;
        logic [4:0]            route;
        logic                  route_gain;
        logic                  route_gnd;
        msc_word_t             last_cmd;
        msc_word_t             snap;
        logic                  aw_got;
        logic [7:0]            aw_addr;
        logic                  w_got;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } msc_sys_s;

    msc_link_s l_r;
    msc_link_s l_nxt;
    msc_sys_s  s_r;
    msc_sys_s  s_nxt;

    logic      link_sel;
    logic      cmd_evt;
    logic      stb_rise;
    msc_op_e   cmd_op;
    logic [3:0] cmd_ch;
    logic [4:0] cmd_arg;
    logic [4:0] cur_entry;
    logic [PW-1:0] ptr_inc;

    // True when the address names one of the mapped registers
    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == `MSC_CTRL_OFS) || (a == `MSC_STATUS_OFS) ||
                     (a == `MSC_GAIN_OFS) || (a == `MSC_LASTCMD_OFS);
    endfunction

    // Gain bit that a route code selects; the cold junction is unity gain
    function automatic logic route_gain_of(input logic [4:0] e, input logic [15:0] g);
        route_gain_of = (e < `MSC_CJ_CODE) ? g[e[3:0]] : 1'b0;
    endfunction

    // Serial link: bits are taken on the rising edge and the outbound bit is
    // changed on the rising edge, so the host samples it on the falling edge
    assign link_sel = (l_r.addr_sh == MOD_ADDR) && backplane_slot_select_n && l_r.en_s;
    always_comb
    begin
        l_nxt       = l_r;
        l_nxt.rst_m = aresetn;
        l_nxt.rst_s = l_r.rst_m;
        l_nxt.en_m  = s_r.link_en;
        l_nxt.en_s  = l_r.en_m;
        if (!l_r.rst_s)
        begin
            l_nxt.addr_sh   = 8'h00;
            l_nxt.bit_cnt   = 4'h0;
            l_nxt.in_sh     = '0;
            l_nxt.out_sh    = '0;
            l_nxt.word_hold = '0;
            l_nxt.word_tgl  = 1'b0;
        end
        else if (data_not_address_qualifier)
        begin
            // Address phase restarts word framing; slot-zero address bits are skipped
            if (backplane_slot_select_n)
            begin
                l_nxt.addr_sh = {l_r.addr_sh[6:0], host_to_module_serial_line};
            end
            l_nxt.bit_cnt = 4'h0;
            // Snapshot changes only after a command, so it is settled by the last address bit
            l_nxt.out_sh  = s_r.snap;
        end
        else if (link_sel)
        begin
            l_nxt.in_sh   = {l_r.in_sh[14:0], host_to_module_serial_line};
            l_nxt.out_sh  = {l_r.out_sh[14:0], 1'b0};
            l_nxt.bit_cnt = l_r.bit_cnt + 4'h1;
            if (l_r.bit_cnt == 4'hF)
            begin
                // Word held stable for a whole word time while the toggle crosses
                l_nxt.word_hold = {l_r.in_sh[14:0], host_to_module_serial_line};
                l_nxt.word_tgl  = ~l_r.word_tgl;
                l_nxt.out_sh    = s_r.snap;
            end
        end
    end

    // Link register bank on the host's serial clock
    always_ff @(posedge serial_shift_clock)
    begin
        l_r <= l_nxt;
    end

    // Outbound line comes straight from a link flop; its enable also decodes the qualifier and slot select inputs
    assign module_to_host_serial_line = l_r.out_sh[15];
    assign module_to_host_serial_oe_n = ~(link_sel && !data_not_address_qualifier);

    // Event decode from synchronised edges
    assign cmd_evt   = s_r.tgl_s ^ s_r.tgl_d;
    assign stb_rise  = s_r.stb_s & ~s_r.stb_d;
    assign cmd_op    = msc_op_e'(l_r.word_hold[`MSC_OP_MSB:`MSC_OP_LSB]);
    assign cmd_ch    = l_r.word_hold[`MSC_CH_MSB:`MSC_CH_LSB];
    assign cmd_arg   = l_r.word_hold[`MSC_ARG_MSB:`MSC_ARG_LSB];
    assign cur_entry = s_r.list[s_r.ptr];
    assign ptr_inc   = s_r.ptr + PW'(1);

    // System-side next state: crossings, commands, scanning and the bus slave
    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.tgl_m = l_r.word_tgl;
        s_nxt.tgl_s = s_r.tgl_m;
        s_nxt.tgl_d = s_r.tgl_s;
        s_nxt.stb_m = scan_advance_strobe;
        s_nxt.stb_s = s_r.stb_m;
        s_nxt.stb_d = s_r.stb_s;

        // Scan strobe steps the list and wraps; the wrap to the first entry ends auto-zero
        if (stb_rise && (s_r.count != '0))
        begin
            if ((CW'(s_r.ptr) + CW'(1)) == s_r.count)
            begin
                s_nxt.ptr     = '0;
                s_nxt.az_pend = 1'b0;
            end
            else
            begin
                s_nxt.ptr = ptr_inc;
            end
        end

        // Commands from the link; a list change rewinds to the first entry
        if (cmd_evt)
        begin
            s_nxt.last_cmd = l_r.word_hold;
            case (cmd_op)
                MSC_OP_GAIN:     s_nxt.gain[cmd_ch] = cmd_arg[0];
                MSC_OP_COUPLE:   s_nxt.ground_sel   = cmd_arg[0];
                MSC_OP_AUTOZERO:
                begin
                    s_nxt.az_en   = cmd_arg[0];
                    s_nxt.az_pend = cmd_arg[0];
                end
                MSC_OP_CLEAR:
                begin
                    s_nxt.count = '0;
                    s_nxt.ptr   = '0;
                end
                MSC_OP_PUSH:
                begin
                    // Any code up to the cold junction is accepted, repeats included
                    if ((cmd_arg <= `MSC_CJ_CODE) && (s_r.count < CW'(DEPTH)))
                    begin
                        s_nxt.list[s_r.count[PW-1:0]] = cmd_arg;
                        s_nxt.count = s_r.count + CW'(1);
                        s_nxt.ptr   = '0;
                    end
                end
                default: s_nxt.last_cmd = l_r.word_hold;
            endcase
            s_nxt.snap = {s_nxt.az_pend, s_nxt.ground_sel, s_nxt.az_en,
                          s_nxt.list[s_nxt.ptr], 8'(s_nxt.count)};
        end

        // Route and gain outputs follow the current entry every cycle; grounding follows auto-zero and coupling
        s_nxt.route      = cur_entry;
        s_nxt.route_gain = route_gain_of(cur_entry, s_r.gain);
        s_nxt.route_gnd  = s_r.az_pend ? 1'b1 : s_r.ground_sel;

        // AXI write: address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
        begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = reg_mapped(s_r.aw_addr) ? RESP_OK : RESP_ERR;
            if ((s_r.aw_addr == `MSC_CTRL_OFS) && s_r.wstrb[0])
            begin
                s_nxt.link_en = s_r.wdata[`MSC_CTRL_LINK_EN];
                if (s_r.wdata[`MSC_CTRL_RESTART])
                begin
                    s_nxt.ptr = '0;
                end
            end
        end
        if (s_r.bvalid && s_axi_bready)
        begin
            s_nxt.bvalid = 1'b0;
        end

        // AXI read: one outstanding, unmapped reads return zero with an error
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = reg_mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
            case (s_axi_araddr)
                `MSC_CTRL_OFS:    s_nxt.rdata = {31'h0000_0000, s_r.link_en};
                `MSC_STATUS_OFS:  s_nxt.rdata = {16'h0000, s_r.az_pend, s_r.ground_sel,
                                                 s_r.az_en, cur_entry, 8'(s_r.count)};
                `MSC_GAIN_OFS:    s_nxt.rdata = {16'h0000, s_r.gain};
                `MSC_LASTCMD_OFS: s_nxt.rdata = {16'h0000, s_r.last_cmd};
                default:          s_nxt.rdata = 32'h0000_0000;
            endcase
        end
        if (s_r.rvalid && s_axi_rready)
        begin
            s_nxt.rvalid = 1'b0;
        end
    end

    // System register bank; reset loads constants only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r         <= '0;
            s_r.link_en <= `MSC_CTRL_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Ready outputs are combinational; valid, response and data outputs come from flops
    assign s_axi_awready      = !s_r.aw_got && !s_r.bvalid;
    assign s_axi_wready       = !s_r.w_got && !s_r.bvalid;
    assign s_axi_bvalid       = s_r.bvalid;
    assign s_axi_bresp        = s_r.bresp;
    assign s_axi_arready      = !s_r.rvalid;
    assign s_axi_rvalid       = s_r.rvalid;
    assign s_axi_rdata        = s_r.rdata;
    assign s_axi_rresp        = s_r.rresp;
    assign mux_route_select   = s_r.route;
    assign mux_gain_100       = s_r.route_gain;
    assign mux_input_grounded = s_r.route_gnd;

endmodule // msc_scan_control

// ===== verif/msc_scan_control_properties.sv
// Port-level checks for the scan control block.
// Assumes it is bound to msc_scan_control and sees only that module's ports.
`timescale 1ns/1ps
module msc_scan_control_properties
(
    input wire logic        aclk,                        // System clock
    input wire logic        aresetn,                     // Reset, low
    input wire logic        s_axi_awvalid,               // Write address valid
    input wire logic        s_axi_awready,               // Write address ready
    input wire logic        s_axi_wvalid,                // Write data valid
    input wire logic        s_axi_wready,                // Write data ready
    input wire logic [1:0]  s_axi_bresp,                 // Write response
    input wire logic        s_axi_bvalid,                // Response valid
    input wire logic        s_axi_bready,                // Response ready
    input wire logic        s_axi_arvalid,               // Read address valid
    input wire logic        s_axi_arready,               // Read address ready
    input wire logic [31:0] s_axi_rdata,                 // Read data
    input wire logic        s_axi_rvalid,                // Read valid
    input wire logic        s_axi_rready,                // Read ready
    input wire logic        serial_shift_clock,          // Link clock
    input wire logic        module_to_host_serial_oe_n,  // Outbound enable, low
    input wire logic        data_not_address_qualifier,  // High for address
    input wire logic        backplane_slot_select_n,     // Low for slot zero
    input wire logic [4:0]  mux_route_select,            // Routed entry
    input wire logic        mux_gain_100                 // Gain of routed entry
);
    // Both write items taken at one edge
    sequence wr_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // One idle cycle, then the response
    sequence wr_answer_s;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_taken_s |=> wr_answer_s) else $error("write response late or early");
    resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped while stalled");
    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
    read_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while stalled");
    read_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
    route_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mux_route_select <= 5'h10) else $error("route code out of range");
    cj_unity_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mux_route_select == 5'h10 |-> !mux_gain_100) else $error("gain on sensor entry");
    slot_quiet_a: assert property (@(posedge serial_shift_clock)
        disable iff (!aresetn) !backplane_slot_select_n |-> module_to_host_serial_oe_n)
        else $error("outbound driven during slot zero traffic");
    addr_quiet_a: assert property (@(posedge serial_shift_clock)
        disable iff (!aresetn) data_not_address_qualifier |-> module_to_host_serial_oe_n)
        else $error("outbound driven in address phase");
endmodule // msc_scan_control_properties

// ===== verif/msc_host_model.sv
// Acquisition controller model: serial link and scan strobe.
// Assumes the bench calls one task at a time; link clock idles low between frames.
`timescale 1ns/1ps
module msc_host_model
(
    output logic      serial_shift_clock,           // Link clock
    output logic      host_to_module_serial_line,   // Inbound bits
    output logic      data_not_address_qualifier,   // High for address
    output logic      backplane_slot_select_n,      // Low for slot zero
    output logic      scan_advance_strobe,          // Sample taken
    input  wire logic module_to_host_serial_line,   // Readback bits
    input  wire logic module_to_host_serial_oe_n    // Low while module drives
);
    logic [15:0] rx_word;  // Last readback word
    wire         line_seen = module_to_host_serial_oe_n ^ module_to_host_serial_line;

    initial
    begin
        {serial_shift_clock, host_to_module_serial_line, scan_advance_strobe} = 3'h0;
        {data_not_address_qualifier, backplane_slot_select_n} = 2'h3;
        rx_word = 16'h0000;
    end

    // Launch while low, module samples on the rising edge; 48 ns cycle
    task automatic bit_cycle(input logic q, input logic d);
        data_not_address_qualifier = q;
        host_to_module_serial_line = d;
        #12 if (!q) rx_word = {rx_word[14:0], line_seen};
        #12 serial_shift_clock = 1'b1;
        #24 serial_shift_clock = 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) bit_cycle(1'b1, 1'b0);
    endtask

    // Address phase then one word, MSB first; selection held for the frame
    task automatic send(input logic [7:0] a, input logic sel_n, input logic [15:0] w);
        backplane_slot_select_n = sel_n;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, a[i]);
        for (int i = 15; i >= 0; i--) bit_cycle(1'b0, w[i]);
        host_to_module_serial_line = ~w[0];  // Released line must not look held
        backplane_slot_select_n = 1'b1;
    endtask

    // Strobe high then low, each well over two system cycles
    task automatic strobe();
        scan_advance_strobe = 1'b1;
        #200 scan_advance_strobe = 1'b0;
        #200;
    endtask
endmodule // msc_host_model

// ===== verif/tb_top.sv
// Self-checking bench: registers over AXI4-Lite, serial commands, scan stepping.
// Assumes the host model and the property checker are compiled beforehand.
`timescale 1ns/1ps
`include "msc_consts.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import msc_pkg::*;
    typedef struct packed {
        logic [7:0] a; logic sn; logic [15:0] w; logic [7:0] ofs;
        logic [15:0] m; logic [15:0] x; logic [4:0] rt; logic g; logic gn;
    } msc_row_s;
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  resp;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         serial_shift_clock, host_to_module_serial_line, module_to_host_serial_line;
    wire         module_to_host_serial_oe_n, data_not_address_qualifier, backplane_slot_select_n;
    wire         scan_advance_strobe, mux_gain_100, mux_input_grounded;
    wire  [4:0]  mux_route_select;
    int          errors = 0, n_checks = 0;
    logic [4:0]  steps [4] = '{5'h10, 5'h03, 5'h03, 5'h10};
    // Address, select, word, register, mask, value, route, gain, grounded
    msc_row_s    rows [12] = '{
        '{8'h01, 1'b1, 16'h5003, 8'h04, 16'h00ff, 16'h0001, 5'h03, 1'b0, 1'b0},
        '{8'h01, 1'b1, 16'h5010, 8'h04, 16'h00ff, 16'h0002, 5'h03, 1'b0, 1'b0},
        '{8'h01, 1'b1, 16'h5003, 8'h04, 16'h00ff, 16'h0003, 5'h03, 1'b0, 1'b0},
        '{8'h01, 1'b1, 16'h5011, 8'h04, 16'h00ff, 16'h0003, 5'h03, 1'b0, 1'b0},
        '{8'h01, 1'b1, 16'h1301, 8'h08, 16'hffff, 16'h0008, 5'h03, 1'b1, 1'b0},
        '{8'h01, 1'b1, 16'h1f01, 8'h08, 16'hffff, 16'h8008, 5'h03, 1'b1, 1'b0},
        '{8'h01, 1'b1, 16'h1300, 8'h08, 16'hffff, 16'h8000, 5'h03, 1'b0, 1'b0},
        '{8'h01, 1'b0, 16'h1301, 8'h08, 16'hffff, 16'h8000, 5'h03, 1'b0, 1'b0},
        '{8'h02, 1'b1, 16'h1301, 8'h08, 16'hffff, 16'h8000, 5'h03, 1'b0, 1'b0},
        '{8'h01, 1'b1, 16'h2001, 8'h04, 16'he000, 16'h4000, 5'h03, 1'b0, 1'b1},
        '{8'h01, 1'b1, 16'h2000, 8'h04, 16'he000, 16'h0000, 5'h03, 1'b0, 1'b0},
        '{8'h01, 1'b1, 16'h7abc, 8'h0c, 16'hffff, 16'h7abc, 5'h03, 1'b0, 1'b0}};

    msc_scan_control i_dut (.*);
    msc_host_model   i_host (.*);

    always #25 aclk = ~aclk;

    // Write: valids held until taken; one stall cycle on the response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t, bv;
        b_t = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!b_t)
        begin
            @(negedge aclk);  // Inputs move on rising edges only, so this is the edge's view
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t  = s_axi_wvalid && s_axi_wready;
            bv   = s_axi_bvalid;
            b_t  = bv && s_axi_bready;
            r    = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            s_axi_bready <= bv && !b_t;
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t, rv;
        r_t = 1'b0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        while (!r_t)
        begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            rv   = s_axi_rvalid;
            r_t  = rv && s_axi_rready;
            d    = s_axi_rdata;
            r    = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            s_axi_rready <= rv && !r_t;
        end
    endtask

    // Link logic resets from a synchronised copy, so the link clock runs meanwhile
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        fork
            i_host.tick(6);
            repeat (10) @(posedge aclk);
        join
        `CHK("reset route", 5'h00, mux_route_select)
        aresetn <= 1'b1;
        i_host.tick(4);
    endtask

    task automatic conclude();
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            i_host.send(rows[i].a, rows[i].sn, rows[i].w);
            repeat (10) @(posedge aclk);
            axi_rd(rows[i].ofs, rd, resp);
            `CHK("reg", rows[i].x, rd[15:0] & rows[i].m)
            `CHK("route", rows[i].rt, mux_route_select)
            `CHK("gain", rows[i].g, mux_gain_100)
            `CHK("ground", rows[i].gn, mux_input_grounded)
        end
        // List {3, 16, 3}: the sensor entry is visited and the list wraps
        foreach (steps[i])
        begin
            i_host.strobe();
            repeat (6) @(posedge aclk);
            `CHK("step", steps[i], mux_route_select)
        end
        // Autozero grounds despite coupling to the terminals, until the list wraps
        i_host.send(`MSC_ADDR_RST, 1'b1, 16'h3001);
        repeat (10) @(posedge aclk);
        `CHK("az on", 1'b1, mux_input_grounded)
        i_host.strobe();
        repeat (6) @(posedge aclk);
        `CHK("az hold", 1'b1, mux_input_grounded)
        i_host.strobe();
        repeat (6) @(posedge aclk);
        `CHK("az done", 1'b0, mux_input_grounded)
        // Second word reads back pending, ground, enable and count
        i_host.send(`MSC_ADDR_RST, 1'b1, 16'h0000);
        repeat (10) @(posedge aclk);
        i_host.send(`MSC_ADDR_RST, 1'b1, 16'h0000);
        `CHK("readback", 11'h103, {i_host.rx_word[15:13], i_host.rx_word[7:0]})
        axi_rd(`MSC_CTRL_OFS, rd, resp);
        `CHK("ctrl reset", 32'h0000_0001, rd)
        axi_wr(`MSC_CTRL_OFS, 32'h0000_0000, resp);
        i_host.send(`MSC_ADDR_RST, 1'b1, 16'h1001);
        repeat (10) @(posedge aclk);
        axi_rd(`MSC_GAIN_OFS, rd, resp);
        `CHK("link off", 32'h0000_8000, rd)
        i_host.strobe();
        axi_wr(`MSC_CTRL_OFS, 32'h0000_0003, resp);
        repeat (3) @(posedge aclk);
        `CHK("restart", 5'h03, mux_route_select)
        i_host.send(`MSC_ADDR_RST, 1'b1, 16'h4000);
        axi_wr(8'h40, 32'h0000_ffff, resp);
        `CHK("wr unmapped", 2'b10, resp)
        axi_rd(8'h40, rd, resp);
        `CHK("rd unmapped", 34'h2_0000_0000, {resp, rd})
        axi_rd(`MSC_STATUS_OFS, rd, resp);
        `CHK("clear", 8'h00, rd[7:0])
        do_reset();
        axi_rd(`MSC_GAIN_OFS, rd, resp);
        `CHK("gain after reset", 32'h0000_0000, rd)
        conclude();
    end

    // Whole run takes well under 100 us; this cuts a hang short
    initial
    begin
        #400_000;
        errors++;
        conclude();
    end
endmodule // tb_top

bind msc_scan_control msc_scan_control_properties i_props (.*);
